// ---- verilog/cel_consts.svh ----
// constants for the communication error logger
`ifndef CEL_CONSTS_SVH
`define CEL_CONSTS_SVH
`define CEL_CODE_FRAME      8'h84
`define CEL_CODE_UNDEF_CMD  8'h88
`define CEL_CODE_UI_BUSY    8'h89
`define CEL_CODE_NVM_BUSY   8'h8A
`define CEL_CODE_RANGE      8'h8C
`define CEL_CODE_EXEC_DIS   8'h8D
`define CEL_HIST_DEPTH      10
`define CEL_WARN_HOLD_NS    1000
`define CEL_CLK_PERIOD_NS   100
`define CEL_WARN_HOLD_CYC   ((`CEL_WARN_HOLD_NS + `CEL_CLK_PERIOD_NS - 1) / `CEL_CLK_PERIOD_NS)
`endif

// ---- verilog/cel_pkg.sv ----
// types for the communication error logger
package cel_pkg;
    typedef logic [7:0] cel_code_t;
endpackage

// ---- verilog/cel_logger.sv ----
// communication error classifier and ten-entry error history
`timescale 1ns/100ps
`default_nettype none
`include "cel_consts.svh"
module cel_logger
    import cel_pkg::*;
#(
    parameter int DEPTH = `CEL_HIST_DEPTH
) (
    // clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_rstn,
    // request outcome, one-cycle pulse per finished request
    input  wire logic       i_req_done,
    input  wire logic       i_frame_err,
    input  wire logic       i_cmd_undefined,
    input  wire logic       i_ui_session,
    input  wire logic       i_nvm_processing,
    input  wire logic       i_internal_busy_flag,
    input  wire logic       i_nvm_alarm,
    input  wire logic       i_data_out_of_range,
    input  wire logic       i_cmd_disallowed,
    // history access
    input  wire logic       i_hist_read,
    input  wire logic [3:0] i_hist_index,
    input  wire logic       i_hist_clear,
    // other warning causes
    input  wire logic       i_other_warning,
    // answers
    output logic            o_refused,
    output logic            o_err_valid,
    output logic [7:0]      o_err_code,
    output logic            o_rd_valid,
    output logic [7:0]      o_rd_code,
    output logic [3:0]      o_hist_count,
    output logic            o_warning_output
);
    localparam int HOLD = `CEL_WARN_HOLD_CYC;

    initial begin
        if (DEPTH < 1 || DEPTH > 15) begin
            $error("cel_logger: DEPTH must be 1..15");
        end
    end

    // level inputs from other logic on this clock need no synchroniser
    cel_code_t hist [DEPTH];
    logic [3:0]  count;
    logic [7:0]  warn_cnt;

    wire logic nvm_block = i_nvm_processing | i_internal_busy_flag | i_nvm_alarm;
    // framing checked first: a damaged frame cannot carry a trusted command
    wire cel_code_t next_code =
        i_frame_err         ? `CEL_CODE_FRAME     :
        i_cmd_undefined     ? `CEL_CODE_UNDEF_CMD :
        i_ui_session        ? `CEL_CODE_UI_BUSY   :
        nvm_block           ? `CEL_CODE_NVM_BUSY  :
        i_data_out_of_range ? `CEL_CODE_RANGE     :
                              `CEL_CODE_EXEC_DIS;
    wire logic any_err = i_frame_err | i_cmd_undefined | i_ui_session | nvm_block
                       | i_data_out_of_range | i_cmd_disallowed;
    wire logic log_en  = i_req_done & any_err;
    wire logic idx_ok  = i_hist_index < count;
    wire logic full    = count == 4'(DEPTH);

    // a clear in the same cycle as a new error leaves just the new error logged
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            count <= 4'h0;
        end else if (log_en) begin
            count <= i_hist_clear ? 4'h1 : (full ? count : count + 4'h1);
        end else if (i_hist_clear) begin
            count <= 4'h0;
        end
    end

    // shift register, entry 0 is newest; the oldest falls off the end
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            for (int i = 0; i < DEPTH; i++) hist[i] <= 8'h00;
        end else if (log_en) begin
            hist[0] <= next_code;
            for (int i = 1; i < DEPTH; i++) hist[i] <= hist[i-1];
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_refused   <= 1'b0;
            o_err_valid <= 1'b0;
            o_err_code  <= 8'h00;
        end else begin
            o_refused   <= log_en;
            o_err_valid <= log_en;
            o_err_code  <= log_en ? next_code : o_err_code;
        end
    end

    // out-of-range index or empty slot reads as zero
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_rd_valid <= 1'b0;
            o_rd_code  <= 8'h00;
        end else begin
            o_rd_valid <= i_hist_read;
            o_rd_code  <= (i_hist_read && idx_ok) ? hist[i_hist_index] : 8'h00;
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_hist_count <= 4'h0;
        end else begin
            o_hist_count <= (log_en || !i_hist_clear) ? (log_en ? (i_hist_clear ? 4'h1 :
                            (full ? count : count + 4'h1)) : count) : 4'h0;
        end
    end

    // communication error warning holds a short while after a frame error, then clears itself
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            warn_cnt         <= 8'h00;
            o_warning_output <= 1'b0;
        end else begin
            if (i_req_done && i_frame_err) begin
                warn_cnt <= 8'(HOLD);
            end else if (warn_cnt != 8'h00) begin
                warn_cnt <= warn_cnt - 8'h01;
            end
            o_warning_output <= i_other_warning || (i_req_done && i_frame_err)
                              || (warn_cnt > 8'h01);
        end
    end
endmodule
`default_nettype wire

// ---- sim/cel_host.sv ----
// host controller model: one request per command word
`timescale 1ns/100ps
`default_nettype none
module cel_host (input wire logic i_clk, input wire logic [7:0] i_cmd,
    output logic o_req_done, output logic [7:0] o_cause);
    always_ff @(posedge i_clk) {o_req_done, o_cause} <= {|i_cmd, i_cmd};
endmodule
`default_nettype wire

// ---- sim/cel_logger_sva.sv ----
// port assertions for cel_logger
`timescale 1ns/100ps
`default_nettype none
module cel_chk (
    input wire logic i_clk, i_rstn, i_req_done, i_frame_err, i_cmd_undefined, i_hist_clear,
    input wire logic o_refused, o_err_valid, o_warning_output,
    input wire logic [3:0] o_hist_count,
    input wire logic [7:0] o_err_code);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    wire frm = i_req_done && i_frame_err;
    wire und = i_req_done && i_cmd_undefined && !i_hist_clear;
    frm_code_a: assert property (frm |=> o_err_code == 8'h84) else $error("frame");
    und_code_a: assert property (und && !i_frame_err |=> o_err_code == 8'h88) else $error("undef");
    warn_hold_a: assert property (frm |=> o_warning_output [*8]) else $error("warn");
    clr_empty_a: assert property (i_hist_clear && !i_req_done |=> o_hist_count == 4'h0) else $error("clear");
    cnt_step_a: assert property (und && o_hist_count < 4'hA |=> o_hist_count == $past(o_hist_count) + 4'h1)
        else $error("step");
    full_keep_a: assert property (und && o_hist_count == 4'hA |=> o_hist_count == 4'hA) else $error("full");
    cnt_max_a: assert property (o_hist_count <= 4'hA) else $error("max");
    ref_pair_a: assert property (o_refused == o_err_valid) else $error("pair");
endmodule
bind cel_logger cel_chk u_chk (.*);
`default_nettype wire

// ---- sim/cel_logger_bench.sv ----
// bench for cel_logger
`timescale 1ns/100ps
`default_nettype none
module cel_logger_bench;
    logic i_clk = 0, i_rstn = 0, i_hist_read = 0, i_hist_clear = 0, i_other_warning = 0, i_req_done;
    logic o_refused, o_err_valid, o_rd_valid, o_warning_output;
    logic [3:0] i_hist_index = 0, o_hist_count;
    logic [7:0] cmd = 0, cause, o_err_code, o_rd_code;
    int n_mismatch = 0, cmp_count = 0;
    always #50 i_clk = ~i_clk;
    cel_host u_host (.i_clk, .i_cmd(cmd), .o_req_done(i_req_done), .o_cause(cause));
    cel_logger u_dut (.*, .i_frame_err(cause[0]), .i_cmd_undefined(cause[1]), .i_ui_session(cause[2]),
        .i_nvm_processing(cause[3]), .i_internal_busy_flag(cause[4]), .i_nvm_alarm(cause[5]),
        .i_data_out_of_range(cause[6]), .i_cmd_disallowed(cause[7]));
    task chk(string nm, logic [7:0] s, logic [7:0] e);
        cmp_count++;
        if (s !== e) n_mismatch++;
        if (s !== e) $display("ERROR %s exp %h seen %h", nm, e, s);
    endtask
    // host adds a cycle, so the code lands two edges after the command
    task lg(logic [7:0] c, logic [7:0] e);
        @(posedge i_clk) cmd <= c;
        @(posedge i_clk) cmd <= 8'h00;
        @(posedge i_clk) #1 chk("code", o_err_code, e);
    endtask
    task acc(logic clr, logic [3:0] x, logic [7:0] e);
        @(posedge i_clk) {i_hist_clear, i_hist_read, i_hist_index} <= {clr, !clr, x};
        @(posedge i_clk) {i_hist_clear, i_hist_read} <= 2'h0;
        #1 chk("hist", clr ? {4'h0, o_hist_count} : o_rd_code, e);
    endtask
    task t_codes;
        logic [7:0] code [8] = '{8'h84, 8'h88, 8'h89, 8'h8A, 8'h8A, 8'h8A, 8'h8C, 8'h8D};
        acc(1'b0, 4'h0, 8'h00);
        for (int i = 0; i < 8; i++) lg(8'h01 << i, code[i]);
        lg(8'h03, 8'h84);
        chk("warn", {7'h0, o_warning_output}, 8'h01);
    endtask
    task t_hist;
        lg(8'h04, 8'h89);
        lg(8'h02, 8'h88);
        acc(1'b0, 4'h9, 8'h88);
        acc(1'b1, 4'h0, 8'h00);
    endtask
    // valid pulses, warning hold and release, other warning cause, read valid
    task t_flags;
        @(posedge i_clk) cmd <= 8'h01;
        @(posedge i_clk) cmd <= 8'h00;
        @(posedge i_clk) #1 chk("valid", {6'h0, o_refused, o_err_valid}, 8'h03);
        chk("warn on", {7'h0, o_warning_output}, 8'h01);
        @(posedge i_clk) #1 chk("pulse", {6'h0, o_refused, o_err_valid}, 8'h00);
        repeat (8) @(posedge i_clk);
        #1 chk("warn held", {7'h0, o_warning_output}, 8'h01);
        @(posedge i_clk) #1 chk("warn off", {7'h0, o_warning_output}, 8'h00);
        @(posedge i_clk) i_other_warning <= 1'b1;
        @(posedge i_clk) i_other_warning <= 1'b0;
        #1 chk("warn other", {7'h0, o_warning_output}, 8'h01);
        acc(1'b0, 4'h0, 8'h84);
        chk("rd valid", {7'h0, o_rd_valid}, 8'h01);
    endtask
    task print_verdict;
        if (n_mismatch == 0 && cmp_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        #100000;
        n_mismatch++;
        print_verdict;
    end
    initial begin
        repeat (4) @(posedge i_clk);
        i_rstn <= 1'b1;
        t_codes;
        t_hist;
        t_flags;
        print_verdict;
    end
endmodule
`default_nettype wire
